// *** logic/kli_pkg.sv ***
// Constants, register map and bus states for the keypad level interrupt block.
// Assumes one 50 MHz clock and a word-aligned register bus.
//
// Contract
// - Each line has enable and level bits.
// - Disabled lines never reach the keypad request.
// - Enabled line flags drive the keypad request.
// - Level bit zero detects a low input.
// - Level bit one detects a high input.
// - Reset clears enable and level bits.
// - Flags set on level, cleared by reading.
// - One global enable gates the shared request.
// - Enabled line detection wakes the chip.
package kli_pkg;

    // ======================================================================
    // Widths.
    localparam int KLI_LINES = 8;
    localparam int KLI_ADDR_W = 10;
    localparam int KLI_DATA_W = 32;

    // ======================================================================
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] KLI_IDX_LEVEL_SELECT = 8'h9c;
    localparam logic [7:0] KLI_IDX_LINE_ENABLE = 8'h9d;
    localparam logic [7:0] KLI_IDX_LINE_FLAG = 8'h9e;
    localparam logic [7:0] KLI_IDX_CTRL = 8'ha0;
    localparam logic [7:0] KLI_IDX_IRQ_STATUS = 8'ha1;
    localparam logic [7:0] KLI_IDX_IRQ_MASK = 8'ha2;
    localparam logic [7:0] KLI_IDX_PORT_LEVEL = 8'ha3;

    // ======================================================================
    // Field positions.
    localparam int KLI_CTRL_GLOBAL_EN_BIT = 0;
    localparam int KLI_ST_FLAG_BIT = 0;
    localparam int KLI_ST_WAKE_BIT = 1;
    localparam int KLI_ST_W = 2;

    // ======================================================================
    // Reset values.
    localparam logic [7:0] KLI_LEVEL_SELECT_RST = 8'h00;
    localparam logic [7:0] KLI_LINE_ENABLE_RST = 8'h00;
    localparam logic [7:0] KLI_LINE_FLAG_RST = 8'h00;
    localparam logic KLI_GLOBAL_EN_RST = 1'b0;
    localparam logic [1:0] KLI_IRQ_STATUS_RST = 2'h0;
    localparam logic [1:0] KLI_IRQ_MASK_RST = 2'h0;

    // ======================================================================
    // Bus handshake states.
    typedef enum logic [1:0] {
        KLI_BUS_IDLE = 2'b01,
        KLI_BUS_ACK = 2'b10
    } kli_bus_e;

endpackage

// *** logic/kli_det_if.sv ***
// Interface between the keypad top and its line detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface kli_det_if;
    logic [7:0] lines_raw;
    logic [7:0] level_select;
    logic [7:0] line_level;
    logic [7:0] line_hit;

    modport det (
        input lines_raw,
        input level_select,
        output line_level,
        output line_hit
    );

    modport host (
        output lines_raw,
        output level_select,
        input line_level,
        input line_hit
    );
endinterface // kli_det_if
`default_nettype wire

// *** logic/kli_line_det.sv ***
// Synchroniser and level comparator for the eight keypad lines.
// Assumes the raw lines are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module kli_line_det (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Detector channel.
    kli_det_if.det dif
);

    // ======================================================================
    // State.
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
    } kli_det_s;

    kli_det_s s_r;
    kli_det_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = dif.lines_raw;
        s_nxt.sync2 = s_r.sync1;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // Port lines idle high, so starting there avoids a false low match after reset.
            s_r <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dif.line_level = s_r.sync2;

    // ======================================================================
    // Per-line level match.
    for (genvar i = 0; i < kli_pkg::KLI_LINES; i++) begin : g_line
        assign dif.line_hit[i] = (s_r.sync2[i] == dif.level_select[i]);
    end

    // ======================================================================
    // Checks.
    a_low_match: assert property (@(posedge mclk) disable iff (rst)
        (!dif.level_select[0] && !s_r.sync2[0]) |-> dif.line_hit[0])
        else $error("Low level on line 0 not detected.");

    a_high_match: assert property (@(posedge mclk) disable iff (rst)
        (dif.level_select[7] && !s_r.sync2[7]) |-> !dif.line_hit[7])
        else $error("Low level wrongly matched in high mode.");

    a_sync_delay: assert property (@(posedge mclk) disable iff (rst)
        $past(rst, 3) == 1'b0 |-> dif.line_level == $past(dif.lines_raw, 2))
        else $error("Line synchroniser delay is not two cycles.");

endmodule // kli_line_det
`default_nettype wire

// *** logic/kli_top.sv ***
// Keypad level interrupt block with an Avalon-MM register slave.
// Assumes keypad lines are asynchronous pins and a 50 MHz mclk.
`timescale 1ns/1ps
`default_nettype none
module kli_top (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave.
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Keypad pins.
    input wire logic [7:0] port_one_lines,
    // Requests.
    output logic keypad_irq,
    output logic wake_req,
    output logic irq
);

    // ======================================================================
    // State.
    typedef struct packed {
        kli_pkg::kli_bus_e st;
        logic wait_r;
        logic [31:0] rdata;
        logic [7:0] level_select;
        logic [7:0] line_enable;
        logic [7:0] line_flag;
        logic global_en;
        logic [1:0] status;
        logic [1:0] mask;
        logic kirq;
        logic wake;
        logic irq;
    } kli_top_s;

    kli_top_s s_r;
    kli_top_s s_nxt;

    logic req;
    logic [7:0] idx;
    logic [7:0] hit;
    logic [7:0] flag_clr;
    logic [1:0] st_clr;
    logic [1:0] st_set;
    logic wake_now;
    logic wr_done;
    logic rd_done;

    // ======================================================================
    // Line detector.
    kli_det_if dif ();

    assign dif.lines_raw = port_one_lines;
    assign dif.level_select = s_r.level_select;

    kli_line_det u_det (
        .mclk(mclk),
        .rst(rst),
        .dif(dif)
    );

    // ======================================================================
    // Next state.
    always_comb begin
        s_nxt = s_r;
        req = avs_read | avs_write;
        idx = avs_address[9:2];
        hit = dif.line_hit;
        flag_clr = 8'h00;
        st_clr = 2'h0;
        wr_done = 1'b0;
        rd_done = 1'b0;
        case (s_r.st)
            kli_pkg::KLI_BUS_IDLE: begin
                if (req) begin
                    s_nxt.st = kli_pkg::KLI_BUS_ACK;
                    s_nxt.wait_r = 1'b0;
                    s_nxt.rdata = 32'h0000_0000;
                    if (avs_read) begin
                        case (idx)
                            kli_pkg::KLI_IDX_LEVEL_SELECT: begin
                                s_nxt.rdata[7:0] = s_r.level_select;
                            end
                            kli_pkg::KLI_IDX_LINE_ENABLE: begin
                                s_nxt.rdata[7:0] = s_r.line_enable;
                            end
                            kli_pkg::KLI_IDX_LINE_FLAG: begin
                                s_nxt.rdata[7:0] = s_r.line_flag;
                            end
                            kli_pkg::KLI_IDX_CTRL: begin
                                s_nxt.rdata[kli_pkg::KLI_CTRL_GLOBAL_EN_BIT] = s_r.global_en;
                            end
                            kli_pkg::KLI_IDX_IRQ_STATUS: begin
                                s_nxt.rdata[1:0] = s_r.status;
                            end
                            kli_pkg::KLI_IDX_IRQ_MASK: begin
                                s_nxt.rdata[1:0] = s_r.mask;
                            end
                            kli_pkg::KLI_IDX_PORT_LEVEL: begin
                                s_nxt.rdata[7:0] = dif.line_level;
                            end
                            default: begin
                                s_nxt.rdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            kli_pkg::KLI_BUS_ACK: begin
                s_nxt.st = kli_pkg::KLI_BUS_IDLE;
                s_nxt.wait_r = 1'b1;
                wr_done = avs_write & avs_byteenable[0];
                rd_done = avs_read;
                if (wr_done) begin
                    case (idx)
                        kli_pkg::KLI_IDX_LEVEL_SELECT: begin
                            s_nxt.level_select = avs_writedata[7:0];
                        end
                        kli_pkg::KLI_IDX_LINE_ENABLE: begin
                            s_nxt.line_enable = avs_writedata[7:0];
                        end
                        kli_pkg::KLI_IDX_CTRL: begin
                            s_nxt.global_en = avs_writedata[kli_pkg::KLI_CTRL_GLOBAL_EN_BIT];
                        end
                        kli_pkg::KLI_IDX_IRQ_STATUS: begin
                            st_clr = avs_writedata[1:0];
                        end
                        kli_pkg::KLI_IDX_IRQ_MASK: begin
                            s_nxt.mask = avs_writedata[1:0];
                        end
                        default: begin
                            st_clr = 2'h0;
                        end
                    endcase
                end
                if (rd_done && idx == kli_pkg::KLI_IDX_LINE_FLAG) begin
                    flag_clr = s_r.rdata[7:0];
                end
            end
            default: begin
                s_nxt.st = kli_pkg::KLI_BUS_IDLE;
                s_nxt.wait_r = 1'b1;
            end
        endcase

        // Flags set on a level match; a set in the clearing cycle wins.
        s_nxt.line_flag = (s_r.line_flag & ~flag_clr) | hit;

        // Shared keypad request and wake-up.
        s_nxt.kirq = s_r.global_en & |(s_r.line_flag & s_r.line_enable);
        wake_now = |(hit & s_r.line_enable);
        s_nxt.wake = wake_now;

        // Sticky event status, write one to clear, set wins.
        st_set = 2'h0;
        st_set[kli_pkg::KLI_ST_FLAG_BIT] = |(hit & ~s_r.line_flag);
        st_set[kli_pkg::KLI_ST_WAKE_BIT] = wake_now & ~s_r.wake;
        s_nxt.status = (s_r.status & ~st_clr) | st_set;
        s_nxt.irq = |(s_r.status & s_r.mask);
    end

    // ======================================================================
    // Registers.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r.st <= kli_pkg::KLI_BUS_IDLE;
            s_r.wait_r <= 1'b1;
            s_r.rdata <= 32'h0000_0000;
            s_r.level_select <= kli_pkg::KLI_LEVEL_SELECT_RST;
            s_r.line_enable <= kli_pkg::KLI_LINE_ENABLE_RST;
            s_r.line_flag <= kli_pkg::KLI_LINE_FLAG_RST;
            s_r.global_en <= kli_pkg::KLI_GLOBAL_EN_RST;
            s_r.status <= kli_pkg::KLI_IRQ_STATUS_RST;
            s_r.mask <= kli_pkg::KLI_IRQ_MASK_RST;
            s_r.kirq <= 1'b0;
            s_r.wake <= 1'b0;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // Outputs.
    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.wait_r;
    assign keypad_irq = s_r.kirq;
    assign wake_req = s_r.wake;
    assign irq = s_r.irq;

    // ======================================================================
    // Checks.
    a_bus_ack_one: assert property (@(posedge mclk) disable iff (rst)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("Request not answered after one cycle.");

    a_bus_ack_release: assert property (@(posedge mclk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("Waitrequest low for more than one cycle.");

    a_cfg_write: assert property (@(posedge mclk) disable iff (rst)
        (avs_write && !avs_waitrequest && avs_byteenable[0]
            && idx == kli_pkg::KLI_IDX_LINE_ENABLE)
        |=> s_r.line_enable == $past(avs_writedata[7:0]))
        else $error("Enable register write not stored.");

    a_reset_clear: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> (s_r.level_select == 8'h00 && s_r.line_enable == 8'h00))
        else $error("Configuration not cleared by reset.");

    a_flag_set: assert property (@(posedge mclk) disable iff (rst)
        |hit |=> (s_r.line_flag & $past(hit)) == $past(hit))
        else $error("Detected level did not set its flag.");

    a_flag_read_clear: assert property (@(posedge mclk) disable iff (rst)
        (avs_read && !avs_waitrequest && idx == kli_pkg::KLI_IDX_LINE_FLAG && hit == 8'h00)
        |=> s_r.line_flag == ($past(s_r.line_flag) & ~$past(s_r.rdata[7:0])))
        else $error("Flag read did not clear flags.");

    a_kirq_form: assert property (@(posedge mclk) disable iff (rst)
        ##1 keypad_irq == $past(s_r.global_en && |(s_r.line_flag & s_r.line_enable)))
        else $error("Keypad request not formed from flags and enables.");

    a_global_gate: assert property (@(posedge mclk) disable iff (rst)
        !s_r.global_en |=> !keypad_irq)
        else $error("Keypad request raised while globally disabled.");

    a_disabled_quiet: assert property (@(posedge mclk) disable iff (rst)
        (s_r.line_enable == 8'h00) |=> !keypad_irq)
        else $error("Keypad request raised with all lines disabled.");

    a_enabled_drive: assert property (@(posedge mclk) disable iff (rst)
        (s_r.global_en && (s_r.line_flag[0] && s_r.line_enable[0])) |=> keypad_irq)
        else $error("Enabled flag did not raise keypad request.");

    a_wake_req: assert property (@(posedge mclk) disable iff (rst)
        ##1 wake_req == $past(|(hit & s_r.line_enable)))
        else $error("Wake request does not follow enabled detection.");

    a_low_detect: assert property (@(posedge mclk) disable iff (rst)
        (s_r.level_select == 8'h00 && dif.line_level == 8'h00) |-> hit == 8'hff)
        else $error("Low levels not detected in low mode.");

    a_high_detect: assert property (@(posedge mclk) disable iff (rst)
        (s_r.level_select == 8'hff && dif.line_level == 8'hff) |-> hit == 8'hff)
        else $error("High levels not detected in high mode.");

    a_irq_level: assert property (@(posedge mclk) disable iff (rst)
        ##1 irq == $past(|(s_r.status & s_r.mask)))
        else $error("Interrupt output does not follow masked status.");

    a_level_write: assert property (@(posedge mclk) disable iff (rst)
        (avs_write && !avs_waitrequest && avs_byteenable[0]
            && idx == kli_pkg::KLI_IDX_LEVEL_SELECT)
        |=> s_r.level_select == $past(avs_writedata[7:0]))
        else $error("Level select register write not stored.");

    a_byte_skip: assert property (@(posedge mclk) disable iff (rst)
        (avs_write && !avs_waitrequest && !avs_byteenable[0])
        |=> (s_r.line_enable == $past(s_r.line_enable)
            && s_r.level_select == $past(s_r.level_select)))
        else $error("Write without low byte enable changed a register.");

    a_ctrl_write: assert property (@(posedge mclk) disable iff (rst)
        (avs_write && !avs_waitrequest && avs_byteenable[0] && idx == kli_pkg::KLI_IDX_CTRL)
        |=> s_r.global_en == $past(avs_writedata[kli_pkg::KLI_CTRL_GLOBAL_EN_BIT]))
        else $error("Global enable write not stored.");

    a_flag_read_data: assert property (@(posedge mclk) disable iff (rst)
        (avs_read && avs_waitrequest && idx == kli_pkg::KLI_IDX_LINE_FLAG)
        |=> avs_readdata[7:0] == $past(s_r.line_flag))
        else $error("Flag read did not return the flags.");

    a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        !(avs_read && !avs_waitrequest && idx == kli_pkg::KLI_IDX_LINE_FLAG)
        |=> (s_r.line_flag & $past(s_r.line_flag)) == $past(s_r.line_flag))
        else $error("Flag cleared without a flag read.");

    a_wake_gate: assert property (@(posedge mclk) disable iff (rst)
        (s_r.line_enable == 8'h00) |=> !wake_req)
        else $error("Wake request raised with all lines disabled.");

    a_rdata_upper: assert property (@(posedge mclk) disable iff (rst)
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("Unused read data bits not zero.");

    a_status_clear: assert property (@(posedge mclk) disable iff (rst)
        (avs_write && !avs_waitrequest && avs_byteenable[0]
            && idx == kli_pkg::KLI_IDX_IRQ_STATUS && st_set == 2'h0)
        |=> s_r.status == ($past(s_r.status) & ~$past(avs_writedata[1:0])))
        else $error("Status write of one did not clear.");

    a_status_hold: assert property (@(posedge mclk) disable iff (rst)
        (!(avs_write && !avs_waitrequest) && st_set == 2'h0)
        |=> s_r.status == $past(s_r.status))
        else $error("Status bit changed without an event or clear.");

    a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
        (s_r.mask == 2'h0) |=> !irq)
        else $error("Interrupt raised with every source masked.");

    a_mask_write: assert property (@(posedge mclk) disable iff (rst)
        (avs_write && !avs_waitrequest && avs_byteenable[0] && idx == kli_pkg::KLI_IDX_IRQ_MASK)
        |=> s_r.mask == $past(avs_writedata[1:0]))
        else $error("Mask register write not stored.");

endmodule // kli_top
`default_nettype wire

// *** logic/kli_top_note_placeholder.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/kli_keypad_model.sv ***
// Matrix keypad model for the keypad level interrupt bench.
// Assumes the bench names the pressed lines and their active level.
`timescale 1ns/1ps
`default_nettype none
module kli_keypad_model (
    // Key control.
    input wire logic [7:0] press,
    input wire logic [7:0] act_level,
    // Port pins.
    output logic [7:0] lines
);
    // ======================================================================
    // Pin levels.
    // A released line rests at the inverse of its active level, never at a stale value.
    assign lines = act_level ^ ~press;
endmodule // kli_keypad_model
`default_nettype wire

// *** tb/kli_top_bench.sv ***
// Self-checking bench for the keypad level interrupt block.
// Assumes the keypad model drives the port pins and the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module kli_top_bench;
    // ======================================================================
    // Signals.
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] port_one_lines;
    logic keypad_irq;
    logic wake_req;
    logic irq;
    logic [7:0] kp_press = 8'h00;
    logic [7:0] kp_level = 8'h00;
    logic [31:0] rd;
    int n_fail = 0;
    int cmp_count = 0;

    always #10 mclk = ~mclk;

    kli_top u_kli_top (
        .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_one_lines(port_one_lines),
        .keypad_irq(keypad_irq), .wake_req(wake_req), .irq(irq)
    );

    kli_keypad_model u_kli_keypad_model (
        .press(kp_press), .act_level(kp_level), .lines(port_one_lines)
    );

    // ======================================================================
    // Common tasks.
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] q);
        int i;
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 20) begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, idx, wd, 4'hf, q);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, 4'hf, rd);
        check(rd, exp);
    endtask

    // ======================================================================
    // Scenarios.
    task automatic s_reset();
        rd_chk(kli_pkg::KLI_IDX_LEVEL_SELECT, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_LINE_FLAG, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_CTRL, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_IRQ_STATUS, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_IRQ_MASK, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_PORT_LEVEL, 32'h0000_00ff);
        check({29'h0, keypad_irq, wake_req, irq}, 32'h0000_0000);
    endtask

    task automatic s_regs();
        logic [31:0] q;
        wr(kli_pkg::KLI_IDX_LEVEL_SELECT, 32'h0000_00a5);
        rd_chk(kli_pkg::KLI_IDX_LEVEL_SELECT, 32'h0000_00a5);
        wr(kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_005a);
        rd_chk(kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_005a);
        bus(1'b1, kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_00ff, 4'he, q);
        rd_chk(kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_005a);
        wr(8'hb0, 32'h0000_0077);
        rd_chk(8'hb0, 32'h0000_0000);
        // Idle pins are high, so every high-select line of 0xa5 has flagged.
        wr(kli_pkg::KLI_IDX_LEVEL_SELECT, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_LINE_FLAG, 32'h0000_00a5);
        wr(kli_pkg::KLI_IDX_LINE_FLAG, 32'h0000_00ff);
        rd_chk(kli_pkg::KLI_IDX_LINE_FLAG, 32'h0000_0000);
        wr(kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_0000);
    endtask

    task automatic s_levels();
        logic [7:0] pol;
        for (int p = 0; p < 2; p++) begin
            pol = (p == 1) ? 8'hff : 8'h00;
            wr(kli_pkg::KLI_IDX_LEVEL_SELECT, {24'h0, pol});
            kp_level <= pol;
            cyc(5);
            bus(1'b0, kli_pkg::KLI_IDX_LINE_FLAG, 32'h0, 4'hf, rd);
            for (int n = 0; n < 8; n++) begin
                kp_press <= 8'h01 << n;
                cyc(4);
                kp_press <= 8'h00;
                cyc(5);
                rd_chk(kli_pkg::KLI_IDX_LINE_FLAG, {24'h0, 8'h01 << n});
                rd_chk(kli_pkg::KLI_IDX_LINE_FLAG, 32'h0000_0000);
            end
        end
        wr(kli_pkg::KLI_IDX_LEVEL_SELECT, 32'h0000_0000);
        kp_level <= 8'h00;
        cyc(5);
        bus(1'b0, kli_pkg::KLI_IDX_LINE_FLAG, 32'h0, 4'hf, rd);
    endtask

    task automatic s_enable();
        wr(kli_pkg::KLI_IDX_CTRL, 32'h0000_0001);
        wr(kli_pkg::KLI_IDX_IRQ_STATUS, 32'h0000_0003);
        kp_press <= 8'h04;
        cyc(6);
        check({30'h0, keypad_irq, wake_req}, 32'h0000_0000);
        rd_chk(kli_pkg::KLI_IDX_PORT_LEVEL, 32'h0000_00fb);
        wr(kli_pkg::KLI_IDX_LINE_ENABLE, 32'h0000_0004);
        cyc(3);
        check({30'h0, keypad_irq, wake_req}, 32'h0000_0003);
        wr(kli_pkg::KLI_IDX_CTRL, 32'h0000_0000);
        cyc(2);
        check({31'h0, keypad_irq}, 32'h0000_0000);
        check({31'h0, wake_req}, 32'h0000_0001);
        wr(kli_pkg::KLI_IDX_CTRL, 32'h0000_0001);
        cyc(2);
        check({31'h0, keypad_irq}, 32'h0000_0001);
    endtask

    task automatic s_irq();
        rd_chk(kli_pkg::KLI_IDX_IRQ_STATUS, 32'h0000_0003);
        check({31'h0, irq}, 32'h0000_0000);
        wr(kli_pkg::KLI_IDX_IRQ_MASK, 32'h0000_0001);
        cyc(2);
        check({31'h0, irq}, 32'h0000_0001);
        kp_press <= 8'h00;
        cyc(5);
        check({30'h0, keypad_irq, wake_req}, 32'h0000_0002);
        rd_chk(kli_pkg::KLI_IDX_LINE_FLAG, 32'h0000_0004);
        cyc(2);
        check({31'h0, keypad_irq}, 32'h0000_0000);
        wr(kli_pkg::KLI_IDX_IRQ_STATUS, 32'h0000_0003);
        cyc(2);
        rd_chk(kli_pkg::KLI_IDX_IRQ_STATUS, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
    endtask

    // ======================================================================
    // Main sequence.
    initial begin
        cyc(2);
        rst <= 1'b0;
        cyc(4);
        s_reset();
        s_regs();
        s_levels();
        s_enable();
        s_irq();
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(4);
        s_reset();
        end_sim();
    end
endmodule // kli_top_bench
`default_nettype wire
